// *** src/clk_switch.sv ***
// Glitchless two-source clock switchover with gating and power-down
// Contract
// R1 - Force output low within three output cycles
// R2 - Low gap lasts at most three cycles
// R3 - Resume output with new source rising edge
// R4 - Forced switch isolates deselected source
// R5 - Forced switch drives output low immediately
// R6 - Restart from currently chosen source
// R7 - Restart only after new-source cycles elapse
// R8 - Controller releases force before changing choice
// R9 - Dead chosen clock: toggle choice, force
// R10 - Dead other clock: assert force
// R11 - Keep force until dead clock repaired
// R12 - Single-source systems hold force low
// R13 - Controller times gate to avoid runts
// R14 - Gate outputs off before power-down
// R15 - Keep gated until power-up completes
// R16 - Power-down pulls both pair outputs high
// R17 - Gated outputs go to gated level
// R18 - Handoff sequenced by flip-flops, no slivers
`include "clk_switch_consts.svh"
module clk_switch #(
  parameter int N_OUT = 6
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources, sampled as pins
  input wire logic src_a,
  input wire logic src_b,
  // Output pairs
  output logic [N_OUT-1:0] out_true,
  output logic [N_OUT-1:0] out_comp
);
  // Every property below runs on the bus clock and sleeps in reset
  default clocking assert_clk @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] a_sync;
  logic [1:0] b_sync;
  // Two flops each; only the second stage is read below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_sync <= 2'h0;
      b_sync <= 2'h0;
    end else begin
      a_sync <= {a_sync[0], src_a};
      b_sync <= {b_sync[0], src_b};
    end
  end
  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  clk_switch_pkg::state_s s_reg;
  clk_switch_pkg::state_s s_next;
  logic choice;
  logic force_sw;
  logic gate_on;
  logic level;
  logic pdn_n;
  logic src_sel;
  logic src_rise;
  logic wr;
  logic rd;
  logic force_rise;
  assign choice = s_reg.ctrl[`CTRL_CHOICE_BIT];
  assign force_sw = s_reg.ctrl[`CTRL_FORCE_BIT];
  assign gate_on = s_reg.ctrl[`CTRL_GATE_BIT];
  assign level = s_reg.ctrl[`CTRL_LEVEL_BIT];
  assign pdn_n = s_reg.ctrl[`CTRL_PDN_BIT];
  // Only the chosen source is ever looked at, so a dead one cannot leak
  assign src_sel = s_reg.sel_now ? b_sync[1] : a_sync[1]; // see R4
  assign src_rise = src_sel & ~s_reg.src_q;
  // The write lands on the edge that also samples pready high
  assign wr = psel & penable & pwrite & s_reg.pready;
  assign rd = psel & ~penable & ~pwrite;
  // Only a fresh force request restarts; holding the bit must leave the
  // output running from the chosen source
  assign force_rise = wr & (paddr == `CTRL_OFFSET)
    & pwdata[`CTRL_FORCE_BIT] & ~force_sw;
  always_comb begin
    s_next = s_reg;
    s_next.pready = psel & ~penable;
    s_next.tick = src_rise;
    s_next.src_q = src_sel;
    if (wr && paddr == `CTRL_OFFSET) begin
      s_next.ctrl = {27'h0, pwdata[4:0]};
    end
    if (rd) begin
      if (paddr == `CTRL_OFFSET) begin
        s_next.prdata = s_reg.ctrl;
      end else if (paddr == `STATUS_OFFSET) begin
        s_next.prdata = {28'h0, s_reg.out_q, s_reg.sel_now,
                         s_reg.phase};
      end else begin
        s_next.prdata = 32'h0;
      end
    end
    case (s_reg.phase)
      clk_switch_pkg::run: begin
        // Follow the source; a new choice waits for a falling edge
        s_next.out_q = src_sel;
        if (choice != s_reg.sel_now) begin
          s_next.phase = clk_switch_pkg::wait_fall;
        end
      end
      clk_switch_pkg::wait_fall: begin
        s_next.out_q = src_sel;
        if (force_sw || !src_sel) begin
          s_next.out_q = 1'b0; // see R1
          s_next.sel_now = choice;
          s_next.cnt = force_sw ? `FORCE_TICKS : `LOW_TICKS;
          s_next.phase = clk_switch_pkg::hold_low;
        end
      end
      default: begin
        // Count rising edges of the new source while low
        s_next.out_q = 1'b0;
        if (s_reg.tick) begin
          s_next.cnt = s_reg.cnt - 2'h1; // see R2 R7 R18
        end
        if (s_reg.cnt == 2'h0 && src_rise) begin
          s_next.out_q = 1'b1; // see R3
          s_next.phase = clk_switch_pkg::run;
        end
      end
    endcase
    // A new force request parks the output at once, whatever the phase,
    // and restarts from the source that the new control word selects
    if (force_rise) begin
      s_next.out_q = 1'b0; // see R5
      s_next.sel_now = pwdata[`CTRL_CHOICE_BIT]; // see R6
      s_next.cnt = `FORCE_TICKS; // see R7
      s_next.phase = clk_switch_pkg::hold_low;
    end
    // Output stage: power-down beats gating beats the clock
    if (!pdn_n) begin
      s_next.true_q = '1; // see R16
      s_next.comp_q = '1;
    end else if (!gate_on) begin
      s_next.true_q = {N_OUT{level}}; // see R17
      s_next.comp_q = {N_OUT{~level}};
    end else begin
      s_next.true_q = {N_OUT{s_reg.out_q}};
      s_next.comp_q = {N_OUT{~s_reg.out_q}};
    end
  end
  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl <= `CTRL_RESET_VAL;
      s_reg.true_q <= '1;
      s_reg.comp_q <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = 1'b0;
  assign out_true = s_reg.true_q;
  assign out_comp = s_reg.comp_q;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Setting the force bit parks the output on the same edge
  low_on_force_a: assert property ( // see R5
    $rose(force_sw) |-> !s_reg.out_q
    && s_reg.phase == clk_switch_pkg::hold_low)
    else $error("output not low after force");
  // Power-down beats the gated level on both halves of every pair
  pd_high_a: assert property ( // see R16
    !pdn_n |=> (&out_true) && (&out_comp))
    else $error("power-down not high");
  // Gated pairs show the level and its inverse
  gate_level_a: assert property ( // see R17
    pdn_n && !gate_on |=> out_true == {N_OUT{$past(level)}}
    && out_comp == {N_OUT{~$past(level)}})
    else $error("gated level wrong");
  // A high phase only ever starts on a source rise
  resume_rise_a: assert property ( // see R3
    $rose(s_reg.out_q) |-> $past(src_rise))
    else $error("resume not on source rise");
  // The old source low is where the switch cuts in
  fall_low_a: assert property ( // see R1
    s_reg.phase == clk_switch_pkg::wait_fall && !src_sel && !force_sw
    |=> s_reg.phase == clk_switch_pkg::hold_low && !s_reg.out_q)
    else $error("no low at falling edge");
  // The low gap always waits on the source now chosen
  sel_follow_a: assert property ( // see R6
    $rose(s_reg.phase == clk_switch_pkg::hold_low)
    |-> s_reg.sel_now == choice)
    else $error("wrong source chosen");
  // No restart while the new source count is still running
  low_hold_a: assert property ( // see R7 R2
    s_reg.phase == clk_switch_pkg::hold_low && s_reg.cnt != 2'h0
    |=> !s_reg.out_q)
    else $error("early restart");
  // With force held only the chosen synchronised source drives the output
  iso_a: assert property ( // see R4 R18
    force_sw && s_reg.phase == clk_switch_pkg::run
    |=> s_reg.out_q == $past(s_reg.sel_now ? b_sync[1] : a_sync[1]))
    else $error("deselected source leaked");
  // Main scenarios: normal switch, force, power-down, restart
  c_switch: cover property (
    s_reg.phase == clk_switch_pkg::wait_fall ##[1:150]
    s_reg.phase == clk_switch_pkg::run);
  c_force: cover property ($rose(force_sw));
  c_pd: cover property ($fell(pdn_n));
  c_restart: cover property (
    s_reg.phase == clk_switch_pkg::hold_low ##1
    s_reg.phase == clk_switch_pkg::run);
endmodule

// *** src/clk_switch_consts.svh ***
// Constants for the glitchless clock switchover block
`ifndef CLK_SWITCH_CONSTS_SVH
`define CLK_SWITCH_CONSTS_SVH
// ****************************************************************
// Register map
// ****************************************************************
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
// ****************************************************************
// Control fields
// ****************************************************************
`define CTRL_CHOICE_BIT 0
`define CTRL_FORCE_BIT 1
`define CTRL_GATE_BIT 2
`define CTRL_LEVEL_BIT 3
`define CTRL_PDN_BIT 4
`define CTRL_RESET_VAL 32'h0000_0014
// ****************************************************************
// Timing counts, in rising edges of the chosen source
// ****************************************************************
`define LOW_TICKS 2'h2
`define FORCE_TICKS 2'h3
`endif

// *** src/clk_switch_pkg.sv ***
// Types for the glitchless clock switchover block
package clk_switch_pkg;
  typedef enum logic [1:0] {run, wait_fall, hold_low} phase_e;
  typedef struct packed {
    logic [31:0] ctrl;
    phase_e phase;
    logic sel_now;
    logic [1:0] cnt;
    logic tick;
    logic src_q;
    logic out_q;
    logic [5:0] true_q;
    logic [5:0] comp_q;
    logic [31:0] prdata;
    logic pready;
  } state_s;
endpackage

// *** test/clk_src_model.sv ***
// Two clock sources that can each be stopped
module clk_src_model (
  // Run controls
  input wire logic run_a,
  input wire logic run_b,
  // Source clocks
  output logic src_a,
  output logic src_b
);
  timeunit 1ns;
  timeprecision 100ps;
  // A dead source parks low, as a failed oscillator would
  initial begin
    src_a = 1'b0;
    src_b = 1'b0;
  end
  always #70 src_a = run_a ? ~src_a : 1'b0;
  always #110 src_b = run_b ? ~src_b : 1'b0;
endmodule

// *** test/tb_top.sv ***
// Testbench for the clock switchover block
`include "clk_switch_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, src_a, src_b;
  logic run_a = 1'b1;
  logic run_b = 1'b1;
  logic [5:0] out_true, out_comp;
  int error_cnt = 0, n_checks = 0, ca = 0, cb = 0, k, c;
  int seed = 32'h7fb7;
  always #5 pclk = ~pclk;
  always @(posedge src_a) ca++;
  always @(posedge src_b) cb++;
  clk_src_model src (.run_a(run_a), .run_b(run_b), .src_a(src_a),
    .src_b(src_b));
  clk_switch uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_a(src_a),
    .src_b(src_b), .out_true(out_true), .out_comp(out_comp));
  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_checks++;
    if (seen !== ex) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    chk("pready", {31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait for an output level
  task wait_out(input logic lvl);
    int t;
    for (t = 0; t < 400 && out_true[0] !== lvl; t++) @(posedge pclk);
    chk("out level", {31'h0, out_true[0]}, {31'h0, lvl});
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence; c holds the model copy of the control word
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CTRL_OFFSET, 32'h0);
    chk("ctrl reset", rd, `CTRL_RESET_VAL);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("slverr", {31'h0, pslverr}, 32'h0);
    // Gate off at a random level, pdn_n high
    for (k = 0; k < 4; k++) begin
      c = ({$random(seed)} % 2) * 8 + 16;
      apb(1'b1, `CTRL_OFFSET, c);
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      chk("ctrl back", rd, c);
      repeat (4) @(posedge pclk);
      chk("gated true", out_true, {6{c[3]}});
      chk("gated comp", out_comp, {6{~c[3]}});
    end
    // Power-down overrides a low gated level
    apb(1'b1, `CTRL_OFFSET, 32'h0);
    repeat (4) @(posedge pclk);
    chk("pd true", out_true, 6'h3f);
    chk("pd comp", out_comp, 6'h3f);
    // Leave power-down with the outputs still gated low
    apb(1'b1, `CTRL_OFFSET, 32'h10);
    repeat (4) @(posedge pclk);
    chk("up true", out_true, 6'h00);
    chk("up comp", out_comp, 6'h3f);
    // Run from a alone with force low; open the gate while a is low
    @(negedge src_a);
    apb(1'b1, `CTRL_OFFSET, 32'h14);
    wait_out(1'b1);
    k = ca;
    apb(1'b1, `CTRL_OFFSET, 32'h15);
    wait_out(1'b0);
    chk("fall delay", ca - k <= 3, 1);
    k = cb;
    wait_out(1'b1);
    chk("low gap", cb - k <= 3, 1);
    chk("resume edge", {out_true[0], src_b}, 2'b11);
    // Force request with b already chosen drops the output, restarts from b
    wait_out(1'b1);
    apb(1'b1, `CTRL_OFFSET, 32'h17);
    k = cb;
    @(posedge pclk);
    #1 chk("force low", out_true[0], 0);
    wait_out(1'b1);
    chk("force wait", cb - k >= 3 && src_b, 1);
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk("status b", rd & 32'h7, 32'h4);
    // Deselected source dies while force is held
    run_a <= 1'b0;
    wait_out(1'b0);
    wait_out(1'b1);
    chk("isolated", {out_true[0], src_b}, 2'b11);
    // Chosen source dies: release force, toggle choice, force again
    run_a <= 1'b1;
    run_b <= 1'b0;
    apb(1'b1, `CTRL_OFFSET, 32'h15);
    apb(1'b1, `CTRL_OFFSET, 32'h14);
    apb(1'b1, `CTRL_OFFSET, 32'h16);
    wait_out(1'b0);
    wait_out(1'b1);
    chk("fail over", {out_true[0], src_a}, 2'b11);
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk("status a", rd & 32'h7, 32'h0);
    tally_and_finish;
  end
  // Watchdog, far beyond the expected run length
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish;
  end
endmodule
